// *** src/ifep_apb.sv ***
// apb slave front end: one wait-free access phase, registered answer
module ifep_apb (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire ifep_pkg::ifep_apb_req_t        req,
    input  wire logic [ifep_pkg::REG_W-1:0]     rd_word,
    output ifep_pkg::ifep_idx_t                 rd_idx,
    output ifep_pkg::ifep_wr_t                  wr,
    output logic                                pready_r,
    output logic                                pslverr_r,
    output logic [ifep_pkg::APB_DW-1:0]         prdata_r
);

    logic                setup;
    logic                access;
    logic                bad;
    ifep_pkg::ifep_idx_t idx;
    logic                pready_nxt;

    assign idx        = ifep_pkg::ifep_decode(req.paddr);
    assign bad        = (idx == ifep_pkg::IFEP_IDX_NONE);
    assign setup      = req.psel & ~req.penable;
    assign access     = req.psel & req.penable & pready_r;
    assign pready_nxt = setup;
    assign rd_idx     = idx;

    // only the two low byte lanes carry register bits
    assign wr.wr    = access & req.pwrite & ~pslverr_r;
    assign wr.idx   = idx;
    assign wr.wmask = {{8{req.pstrb[1]}}, {8{req.pstrb[0]}}};
    assign wr.wdata = req.pwdata[ifep_pkg::REG_W-1:0];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end else begin
            pready_r  <= pready_nxt;
            pslverr_r <= setup & bad;
            if (setup & ~req.pwrite) begin
                prdata_r <= {{(ifep_pkg::APB_DW-ifep_pkg::REG_W){1'b0}}, rd_word};
            end
        end
    end

endmodule : ifep_apb

// *** src/ifep_pick.sv ***
// picks the highest-level live source and registers its level and index
module ifep_pick #(
    parameter int unsigned N  = 4,
    parameter int unsigned LW = 3,
    parameter int unsigned SW = 2
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic [N-1:0]    valid,
    input  wire logic [N*LW-1:0] levels,
    output logic                 req_r,
    output logic [LW-1:0]        level_r,
    output logic [SW-1:0]        src_r
);

    // ties go to the lowest index, keeping the choice stable
    function automatic logic [SW+LW:0] pick(input logic [N-1:0] v, input logic [N*LW-1:0] l);
        logic [LW-1:0] best;
        logic [SW-1:0] who;
        logic          any;
        best = '0;
        who  = '0;
        any  = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (v[i] && (!any || l[i*LW +: LW] > best)) begin
                best = l[i*LW +: LW];
                who  = SW'(i);
                any  = 1'b1;
            end
        end
        pick = {any, best, who};
    endfunction : pick

    logic [SW+LW:0] res;

    assign res = pick(valid, levels);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_r   <= 1'b0;
            level_r <= '0;
            src_r   <= '0;
        end else begin
            req_r   <= res[SW+LW];
            level_r <= res[SW+LW-1:SW];
            src_r   <= res[SW-1:0];
        end
    end

endmodule : ifep_pick

// *** src/ifep_pkg.sv ***
// shared constants, types and helpers for the interrupt flag, enable and priority block
package ifep_pkg;

    localparam int unsigned REG_W      = 16;
    localparam int unsigned APB_AW     = 12;
    localparam int unsigned APB_DW     = 32;
    localparam int unsigned PRIO_W     = 3;
    localparam int unsigned PAIR_N     = 6;
    localparam int unsigned PRIO_SRC_N = 4;
    localparam int unsigned IDX_W      = 3;

    // byte addresses of the register words
    localparam logic [APB_AW-1:0] OFF_FLAGS_C = 12'h000;
    localparam logic [APB_AW-1:0] OFF_EN_A    = 12'h004;
    localparam logic [APB_AW-1:0] OFF_EN_B    = 12'h008;
    localparam logic [APB_AW-1:0] OFF_EN_C    = 12'h00c;
    localparam logic [APB_AW-1:0] OFF_PRIO_A  = 12'h010;

    typedef enum logic [IDX_W-1:0] {
        IFEP_IDX_FLAGS_C = 3'h0,
        IFEP_IDX_EN_A    = 3'h1,
        IFEP_IDX_EN_B    = 3'h2,
        IFEP_IDX_EN_C    = 3'h3,
        IFEP_IDX_PRIO_A  = 3'h4,
        IFEP_IDX_NONE    = 3'h7
    } ifep_idx_t;

    // implemented bit positions; all others read zero and ignore writes
    localparam logic [REG_W-1:0] FLAGS_C_MASK = 16'h07e1;
    localparam logic [REG_W-1:0] EN_A_MASK    = 16'h7fef;
    localparam logic [REG_W-1:0] EN_B_MASK    = 16'he87f;
    localparam logic [REG_W-1:0] EN_C_MASK    = 16'h07e1;
    localparam logic [REG_W-1:0] PRIO_A_MASK  = 16'h7777;

    localparam logic [REG_W-1:0] FLAGS_RST    = 16'h0000;
    localparam logic [REG_W-1:0] EN_RST       = 16'h0000;
    localparam logic [REG_W-1:0] PRIO_A_RST   = 16'h4444;

    localparam int unsigned PAIR_LSB = 5;
    localparam int unsigned CMP4_BIT = 0;

    // priority field low bits in the priority word
    localparam int unsigned TMR1_PRIO_LSB = 12;
    localparam int unsigned CMP1_PRIO_LSB = 8;
    localparam int unsigned CAP1_PRIO_LSB = 4;
    localparam int unsigned EXT0_PRIO_LSB = 0;

    // enable and flag bit of the same sources in bank a
    localparam int unsigned TMR1_BIT = 3;
    localparam int unsigned CMP1_BIT = 2;
    localparam int unsigned CAP1_BIT = 1;
    localparam int unsigned EXT0_BIT = 0;

    localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [APB_AW-1:0] paddr;
        logic [APB_DW-1:0] pwdata;
        logic [3:0]        pstrb;
    } ifep_apb_req_t;

    typedef struct packed {
        logic             wr;
        ifep_idx_t        idx;
        logic [REG_W-1:0] wmask;
        logic [REG_W-1:0] wdata;
    } ifep_wr_t;

    function automatic ifep_idx_t ifep_decode(input logic [APB_AW-1:0] addr);
        case (addr)
            OFF_FLAGS_C: ifep_decode = IFEP_IDX_FLAGS_C;
            OFF_EN_A:    ifep_decode = IFEP_IDX_EN_A;
            OFF_EN_B:    ifep_decode = IFEP_IDX_EN_B;
            OFF_EN_C:    ifep_decode = IFEP_IDX_EN_C;
            OFF_PRIO_A:  ifep_decode = IFEP_IDX_PRIO_A;
            default:     ifep_decode = IFEP_IDX_NONE;
        endcase
    endfunction : ifep_decode

    // merge a masked write into a register word
    function automatic logic [REG_W-1:0] ifep_merge(input logic [REG_W-1:0] old_v,
                                                    input logic [REG_W-1:0] new_v,
                                                    input logic [REG_W-1:0] wm,
                                                    input logic [REG_W-1:0] impl);
        ifep_merge = ((old_v & ~wm) | (new_v & wm)) & impl;
    endfunction : ifep_merge

endpackage : ifep_pkg

// *** src/ifep_top.sv ***
// interrupt flag, enable and priority block with apb register access
module ifep_top (
    input  wire logic                            clk,
    input  wire logic                            rst,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [ifep_pkg::APB_AW-1:0]     paddr,
    input  wire logic [ifep_pkg::APB_DW-1:0]     pwdata,
    input  wire logic [3:0]                      pstrb,
    output logic      [ifep_pkg::APB_DW-1:0]     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire logic [ifep_pkg::PAIR_N-1:0]     pair_done_evt,
    input  wire logic                            comparator_four_evt,
    input  wire logic [ifep_pkg::REG_W-1:0]      flags_bank_a,
    input  wire logic [ifep_pkg::REG_W-1:0]      flags_bank_b,
    output logic      [ifep_pkg::REG_W-1:0]      req_bank_a,
    output logic      [ifep_pkg::REG_W-1:0]      req_bank_b,
    output logic      [ifep_pkg::REG_W-1:0]      req_bank_c,
    output logic                                 core_req,
    output logic      [ifep_pkg::PRIO_W-1:0]     core_level,
    output logic      [1:0]                      core_src
);

    ifep_pkg::ifep_apb_req_t             apb_req;
    ifep_pkg::ifep_wr_t                  wr;
    ifep_pkg::ifep_idx_t                 rd_idx;
    logic [ifep_pkg::REG_W-1:0]          rd_word;

    logic [ifep_pkg::REG_W-1:0]          flags_c_r;
    logic [ifep_pkg::REG_W-1:0]          flags_c_nxt;
    logic [ifep_pkg::REG_W-1:0]          en_a_r;
    logic [ifep_pkg::REG_W-1:0]          en_a_nxt;
    logic [ifep_pkg::REG_W-1:0]          en_b_r;
    logic [ifep_pkg::REG_W-1:0]          en_b_nxt;
    logic [ifep_pkg::REG_W-1:0]          en_c_r;
    logic [ifep_pkg::REG_W-1:0]          en_c_nxt;
    logic [ifep_pkg::REG_W-1:0]          prio_a_r;
    logic [ifep_pkg::REG_W-1:0]          prio_a_nxt;
    logic [ifep_pkg::REG_W-1:0]          set_c;
    logic [ifep_pkg::REG_W-1:0]          req_a_r;
    logic [ifep_pkg::REG_W-1:0]          req_b_r;
    logic [ifep_pkg::REG_W-1:0]          req_c_r;

    logic [ifep_pkg::PRIO_W-1:0]         lvl_tmr1;
    logic [ifep_pkg::PRIO_W-1:0]         lvl_cmp1;
    logic [ifep_pkg::PRIO_W-1:0]         lvl_cap1;
    logic [ifep_pkg::PRIO_W-1:0]         lvl_ext0;
    logic [ifep_pkg::PRIO_SRC_N-1:0]     prio_valid;
    logic [ifep_pkg::PRIO_SRC_N*ifep_pkg::PRIO_W-1:0] prio_levels;

    logic                                wr_flags;
    logic                                wr_en_a;
    logic                                wr_en_b;
    logic                                wr_en_c;
    logic                                wr_prio;

    assign apb_req = '{psel: psel, penable: penable, pwrite: pwrite,
                       paddr: paddr, pwdata: pwdata, pstrb: pstrb};

    ifep_apb u_apb (
        .clk       (clk),
        .rst       (rst),
        .req       (apb_req),
        .rd_word   (rd_word),
        .rd_idx    (rd_idx),
        .wr        (wr),
        .pready_r  (pready),
        .pslverr_r (pslverr),
        .prdata_r  (prdata)
    );

    assign wr_flags = wr.wr & (wr.idx == ifep_pkg::IFEP_IDX_FLAGS_C);
    assign wr_en_a  = wr.wr & (wr.idx == ifep_pkg::IFEP_IDX_EN_A);
    assign wr_en_b  = wr.wr & (wr.idx == ifep_pkg::IFEP_IDX_EN_B);
    assign wr_en_c  = wr.wr & (wr.idx == ifep_pkg::IFEP_IDX_EN_C);
    assign wr_prio  = wr.wr & (wr.idx == ifep_pkg::IFEP_IDX_PRIO_A);

    // hardware events; software can only clear what is not being set this cycle
    assign set_c = (ifep_pkg::REG_W'(pair_done_evt) << ifep_pkg::PAIR_LSB)
                 | (ifep_pkg::REG_W'(comparator_four_evt) << ifep_pkg::CMP4_BIT);

    assign flags_c_nxt = (wr_flags ? ifep_pkg::ifep_merge(flags_c_r, wr.wdata, wr.wmask, ifep_pkg::FLAGS_C_MASK)
                                   : flags_c_r)
                       | (set_c & ifep_pkg::FLAGS_C_MASK);
    assign en_a_nxt   = wr_en_a ? ifep_pkg::ifep_merge(en_a_r, wr.wdata, wr.wmask, ifep_pkg::EN_A_MASK)
                                : en_a_r;
    assign en_b_nxt   = wr_en_b ? ifep_pkg::ifep_merge(en_b_r, wr.wdata, wr.wmask, ifep_pkg::EN_B_MASK)
                                : en_b_r;
    assign en_c_nxt   = wr_en_c ? ifep_pkg::ifep_merge(en_c_r, wr.wdata, wr.wmask, ifep_pkg::EN_C_MASK)
                                : en_c_r;
    assign prio_a_nxt = wr_prio ? ifep_pkg::ifep_merge(prio_a_r, wr.wdata, wr.wmask, ifep_pkg::PRIO_A_MASK)
                                : prio_a_r;

    // read mux; stored words already hold zeros in unimplemented places
    assign rd_word = (rd_idx == ifep_pkg::IFEP_IDX_FLAGS_C) ? flags_c_r :
                     (rd_idx == ifep_pkg::IFEP_IDX_EN_A)    ? en_a_r    :
                     (rd_idx == ifep_pkg::IFEP_IDX_EN_B)    ? en_b_r    :
                     (rd_idx == ifep_pkg::IFEP_IDX_EN_C)    ? en_c_r    :
                     (rd_idx == ifep_pkg::IFEP_IDX_PRIO_A)  ? prio_a_r  : '0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_c_r <= ifep_pkg::FLAGS_RST;
            en_a_r    <= ifep_pkg::EN_RST;
            en_b_r    <= ifep_pkg::EN_RST;
            en_c_r    <= ifep_pkg::EN_RST;
            prio_a_r  <= ifep_pkg::PRIO_A_RST;
        end else begin
            flags_c_r <= flags_c_nxt;
            en_a_r    <= en_a_nxt;
            en_b_r    <= en_b_nxt;
            en_c_r    <= en_c_nxt;
            prio_a_r  <= prio_a_nxt;
        end
    end

    // gated requests per bank; bank a/b flags arrive from the neighbouring flag registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_a_r <= '0;
            req_b_r <= '0;
            req_c_r <= '0;
        end else begin
            req_a_r <= flags_bank_a & en_a_r & ifep_pkg::EN_A_MASK;
            req_b_r <= flags_bank_b & en_b_r & ifep_pkg::EN_B_MASK;
            req_c_r <= flags_c_r & en_c_r;
        end
    end

    assign req_bank_a = req_a_r;
    assign req_bank_b = req_b_r;
    assign req_bank_c = req_c_r;

    assign lvl_tmr1 = prio_a_r[ifep_pkg::TMR1_PRIO_LSB +: ifep_pkg::PRIO_W];
    assign lvl_cmp1 = prio_a_r[ifep_pkg::CMP1_PRIO_LSB +: ifep_pkg::PRIO_W];
    assign lvl_cap1 = prio_a_r[ifep_pkg::CAP1_PRIO_LSB +: ifep_pkg::PRIO_W];
    assign lvl_ext0 = prio_a_r[ifep_pkg::EXT0_PRIO_LSB +: ifep_pkg::PRIO_W];

    // a zero level drops the source out of the pick entirely
    assign prio_valid[3] = flags_bank_a[ifep_pkg::TMR1_BIT] & en_a_r[ifep_pkg::TMR1_BIT]
                         & (lvl_tmr1 != ifep_pkg::PRIO_OFF);
    assign prio_valid[2] = flags_bank_a[ifep_pkg::CMP1_BIT] & en_a_r[ifep_pkg::CMP1_BIT]
                         & (lvl_cmp1 != ifep_pkg::PRIO_OFF);
    assign prio_valid[1] = flags_bank_a[ifep_pkg::CAP1_BIT] & en_a_r[ifep_pkg::CAP1_BIT]
                         & (lvl_cap1 != ifep_pkg::PRIO_OFF);
    assign prio_valid[0] = flags_bank_a[ifep_pkg::EXT0_BIT] & en_a_r[ifep_pkg::EXT0_BIT]
                         & (lvl_ext0 != ifep_pkg::PRIO_OFF);
    assign prio_levels   = {lvl_tmr1, lvl_cmp1, lvl_cap1, lvl_ext0};

    ifep_pick #(
        .N  (ifep_pkg::PRIO_SRC_N),
        .LW (ifep_pkg::PRIO_W),
        .SW (2)
    ) u_pick (
        .clk     (clk),
        .rst     (rst),
        .valid   (prio_valid),
        .levels  (prio_levels),
        .req_r   (core_req),
        .level_r (core_level),
        .src_r   (core_src)
    );

    property p_pair_set;
        @(posedge clk) disable iff (rst)
        (pair_done_evt != '0) |=>
            ((flags_c_r[ifep_pkg::PAIR_LSB +: ifep_pkg::PAIR_N] & $past(pair_done_evt)) == $past(pair_done_evt));
    endproperty
    a_pair_set: assert property (p_pair_set) else $error("pair done event lost");

    property p_cmp4_set;
        @(posedge clk) disable iff (rst)
        comparator_four_evt |=> flags_c_r[ifep_pkg::CMP4_BIT]
            ##1 (req_bank_c[ifep_pkg::CMP4_BIT] == $past(en_c_r[ifep_pkg::CMP4_BIT]));
    endproperty
    a_cmp4_set: assert property (p_cmp4_set) else $error("comparator four flag not set");

    property p_enable_gates;
        @(posedge clk) disable iff (rst)
        ##1 (req_bank_c == ($past(flags_c_r) & $past(en_c_r)));
    endproperty
    a_enable_gates: assert property (p_enable_gates) else $error("bank c request not flag and enable");

    property p_en_a_write;
        @(posedge clk) disable iff (rst)
        (wr_en_a && wr.wmask == 16'hffff) |=> (en_a_r == ($past(wr.wdata) & ifep_pkg::EN_A_MASK));
    endproperty
    a_en_a_write: assert property (p_en_a_write) else $error("bank a enable write wrong");

    property p_en_b_hold;
        @(posedge clk) disable iff (rst)
        !wr_en_b |=> $stable(en_b_r);
    endproperty
    a_en_b_hold: assert property (p_en_b_hold) else $error("bank b enable changed without write");

    property p_unimpl_zero;
        @(posedge clk) disable iff (rst)
        ((flags_c_r & ~ifep_pkg::FLAGS_C_MASK) == '0) && ((en_c_r & ~ifep_pkg::EN_C_MASK) == '0)
        && ((en_b_r & ~ifep_pkg::EN_B_MASK) == '0) && ((prio_a_r & ~ifep_pkg::PRIO_A_MASK) == '0);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

    property p_zero_level_silent;
        @(posedge clk) disable iff (rst)
        (lvl_tmr1 == ifep_pkg::PRIO_OFF && lvl_cmp1 == ifep_pkg::PRIO_OFF
         && lvl_cap1 == ifep_pkg::PRIO_OFF && lvl_ext0 == ifep_pkg::PRIO_OFF) |=> !core_req;
    endproperty
    a_zero_level_silent: assert property (p_zero_level_silent) else $error("request at level zero");

    property p_level_nonzero;
        @(posedge clk) disable iff (rst)
        core_req |-> (core_level != ifep_pkg::PRIO_OFF);
    endproperty
    a_level_nonzero: assert property (p_level_nonzero) else $error("core request without level");

    property p_timer_level;
        @(posedge clk) disable iff (rst)
        (prio_valid == 4'h8) |=> (core_req && core_src == 2'h3 && core_level == $past(lvl_tmr1));
    endproperty
    a_timer_level: assert property (p_timer_level) else $error("timer one level not forwarded");

    property p_reset_values;
        @(posedge clk) disable iff (rst)
        $fell(rst) |-> (prio_a_r == ifep_pkg::PRIO_A_RST && en_a_r == '0 && en_c_r == '0);
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset value wrong");

    property p_need_all_three;
        @(posedge clk) disable iff (rst)
        // the registered source index was picked a cycle ago, from the eligibility of that cycle
        core_req |-> ((($past(prio_valid) >> core_src) & 4'h1) != 4'h0);
    endproperty
    a_need_all_three: assert property (p_need_all_three) else $error("request from an ineligible source");

    property p_set_beats_clear;
        @(posedge clk) disable iff (rst)
        (wr_flags && comparator_four_evt) |=> flags_c_r[ifep_pkg::CMP4_BIT];
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear) else $error("clear beat a hardware set");

endmodule : ifep_top

// *** verif/ifep_src_model.sv ***
// peripheral event sources: register bench requests into event lines, one cycle later
module ifep_src_model (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic [ifep_pkg::PAIR_N-1:0] fire_pair,
    input  wire logic                        fire_cmp,
    output logic      [ifep_pkg::PAIR_N-1:0] pair_done_evt,
    output logic                             comparator_four_evt
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pair_done_evt       <= '0;
            comparator_four_evt <= 1'b0;
        end else begin
            pair_done_evt       <= fire_pair;
            comparator_four_evt <= fire_cmp;
        end
    end
endmodule : ifep_src_model

// *** verif/tb_interrupt_flag_enable_priority.sv ***
// self-checking bench: register map, events, request gating and priority pick
module tb_interrupt_flag_enable_priority;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, fire_cmp = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r, r2, r3, seed = 32'h0000001e;
    logic [3:0]  pstrb = 4'hf;
    logic [5:0]  fire_pair = '0, pev;
    logic [15:0] fa = '0, fb = '0, rqa, rqb, rqc, ena;
    logic        pready, pslverr, cev, creq;
    logic [2:0]  clvl, best, lv;
    logic [1:0]  csrc, bsrc;
    logic [32:0] e, expq[$];
    int          fails = 0, n_compared = 0, cycles = 0;
    logic [11:0] offs [5] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010};
    logic [15:0] msk [5] = '{16'h07e1, 16'h7fef, 16'he87f, 16'h07e1, 16'h7777};
    logic [15:0] rstv [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h4444};
    always #2.5 clk = ~clk;
    ifep_src_model u_src (.clk(clk), .rst(rst), .fire_pair(fire_pair), .fire_cmp(fire_cmp),
                          .pair_done_evt(pev), .comparator_four_evt(cev));
    ifep_top u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
                    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
                    .pair_done_evt(pev), .comparator_four_evt(cev), .flags_bank_a(fa), .flags_bank_b(fb),
                    .req_bank_a(rqa), .req_bank_b(rqb), .req_bank_c(rqc), .core_req(creq),
                    .core_level(clvl), .core_src(csrc));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            $display("wrong value %s expected %h seen %h", nm, x, g);
            fails++;
        end
    endtask : chk
    // master holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x,
                       input logic [3:0] s = 4'hf);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        if (!wr) expq.push_back(x);
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite) begin
            e = expq.pop_front();
            chk("prdata", e[31:0], prdata);
            chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            finish_test();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) apb(0, offs[i], 0, {17'h0, rstv[i]});
        for (int i = 0; i < 5; i++) begin
            apb(1, offs[i], 32'hffffffff, 0);
            apb(0, offs[i], 0, {17'h0, msk[i]});
        end
        repeat (3) @(posedge clk);
        chk("req_bank_c", 32'h07e1, {16'h0, rqc});
        apb(1, 12'h004, 32'h0, 0, 4'h1);
        apb(0, 12'h004, 0, {17'h0, 16'h7f00});
        apb(1, 12'h014, 32'hffffffff, 0);
        apb(0, 12'h014, 0, {1'b1, 32'h0});
        apb(1, 12'h000, 0, 0);
        $display("test register map done");
        for (int n = 0; n < 7; n++) begin
            @(posedge clk);
            fire_pair <= (n < 6) ? 6'(1 << n) : 6'h0;
            fire_cmp <= (n == 6);
            @(posedge clk);
            fire_pair <= '0;
            fire_cmp <= 1'b0;
            repeat (4) @(posedge clk);
            chk("req_bank_c", (n < 6) ? 32'(1 << (5 + n)) : 32'h1, {16'h0, rqc});
            apb(0, 12'h000, 0, {1'b0, (n < 6) ? 32'(1 << (5 + n)) : 32'h1});
            apb(1, 12'h000, 0, 0);
        end
        apb(1, 12'h00c, 0, 0);
        fire_pair <= 6'h01;
        @(posedge clk);
        fire_pair <= '0;
        repeat (4) @(posedge clk);
        chk("req_bank_c", 32'h0, {16'h0, rqc});
        apb(0, 12'h000, 0, {1'b0, 32'h20});
        // comparator event lands on the very edge that the clearing write takes effect
        fork
            apb(1, 12'h000, 0, 0);
            begin
                @(posedge clk);
                fire_cmp <= 1'b1;
                @(posedge clk);
                fire_cmp <= 1'b0;
            end
        join
        apb(0, 12'h000, 0, {1'b0, 32'h1});
        apb(1, 12'h000, 0, 0);
        $display("test events done");
        for (int k = 0; k < 24; k++) begin
            r = xs();
            r2 = xs();
            r3 = xs();
            fa <= r[15:0];
            fb <= r[31:16];
            apb(1, 12'h004, {16'h0, r2[15:0]}, 0);
            apb(1, 12'h008, {16'h0, r2[31:16]}, 0);
            apb(1, 12'h010, r3, 0);
            repeat (3) @(posedge clk);
            ena = r2[15:0] & 16'h7fef;
            chk("req_bank_a", {16'h0, r[15:0] & ena}, {16'h0, rqa});
            chk("req_bank_b", {16'h0, r[31:16] & r2[31:16] & 16'he87f}, {16'h0, rqb});
            best = 3'h0;
            bsrc = 2'h0;
            for (int s = 0; s < 4; s++) begin
                lv = r3[4*s +: 3];
                if (r[s] && ena[s] && lv > best) begin
                    best = lv;
                    bsrc = 2'(s);
                end
            end
            chk("core_req", {31'h0, best != 3'h0}, {31'h0, creq});
            if (best != 3'h0) begin
                chk("core_level", {29'h0, best}, {29'h0, clvl});
                chk("core_src", {30'h0, bsrc}, {30'h0, csrc});
            end
        end
        fa <= 16'h000f;
        apb(1, 12'h004, 32'h0000000f, 0);
        apb(1, 12'h010, 32'h0, 0);
        repeat (3) @(posedge clk);
        chk("core_req", 32'h0, {31'h0, creq});
        apb(1, 12'h010, 32'h00000777, 0);
        repeat (3) @(posedge clk);
        chk("core_req", 32'h1, {31'h0, creq});
        chk("core_level", 32'h7, {29'h0, clvl});
        chk("core_src", 32'h0, {30'h0, csrc});
        $display("test priority pick done");
        finish_test();
    end
endmodule : tb_interrupt_flag_enable_priority
